// File: inc/rsh_map.svh
// register offsets, field positions and reset values of the reference switch block
`ifndef RSH_MAP_SVH
`define RSH_MAP_SVH
`define RSH_OFF_CTRL        12'h000
`define RSH_OFF_DAC_MAN     12'h004
`define RSH_OFF_TRIP        12'h008
`define RSH_OFF_DAC_DIV     12'h00C
`define RSH_OFF_DIVIDERS    12'h010
`define RSH_OFF_LOCK        12'h014
`define RSH_OFF_STATUS      12'h018
`define RSH_F_MODE_LO       0
`define RSH_F_MODE_HI       2
`define RSH_F_SEL_INV       3
`define RSH_F_HOLD_LO       4
`define RSH_F_HOLD_HI       5
`define RSH_F_FORCE         6
`define RSH_F_LOSS_OFF      7
`define RSH_F_RAIL_EN       8
`define RSH_F_TRACK_EN      9
`define RSH_F_MAN_EN        10
`define RSH_F_EN_A          11
`define RSH_F_EN_B          12
`define RSH_F_LDPIN_LO      13
`define RSH_F_LDPIN_HI      14
`define RSH_MODE_MAN_A      3'h0
`define RSH_MODE_MAN_B      3'h1
`define RSH_MODE_AUTO       3'h4
`define RSH_MODE_AUTO_PIN   3'h6
`define RSH_HOLD_ENABLED    2'h2
`define RSH_CTRL_RESET      32'h0000_1800
`define RSH_DAC_MAN_RESET   32'h0000_0200
`define RSH_TRIP_RESET      32'h03F0_0010
`define RSH_DAC_DIV_RESET   32'h0000_0004
`define RSH_DIVIDERS_RESET  32'h0001_0001
`define RSH_LOCK_RESET      32'h0004_0002
`endif

// File: inc/rsh_pkg.sv
// types shared by the reference switch and holdover controller
package rsh_pkg;
	localparam int DIV_W = 14;
	localparam int DAC_W = 10;
	localparam int CNT_W = 16;
	typedef enum logic [1:0] {
		RSH_RUN  = 2'b00,
		RSH_HOLD = 2'b01
	} rsh_hold_t;
	typedef struct packed {
		logic [31:0] ctrl;
		logic [31:0] dacMan;
		logic [31:0] trip;
		logic [31:0] dacDiv;
		logic [31:0] dividers;
		logic [31:0] lockCfg;
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
		logic        prevRef;
		logic        prevFb;
		logic [DIV_W-1:0] refCnt;
		logic [DIV_W-1:0] fbCnt;
		logic        pendRef;
		logic        pendFb;
		logic [CNT_W-1:0] errCnt;
		logic [CNT_W-1:0] lockCnt;
		logic        locked;
		logic [CNT_W-1:0] dacTick;
		logic [DAC_W-1:0] dacCount;
		logic        activeB;
		logic        armed;
		rsh_hold_t   hold;
		logic        lockFlag;
		logic        lockPin;
		logic        loop2Flag;
		logic [DAC_W-1:0] tuneOut;
	} rsh_state_t;
endpackage : rsh_pkg

// File: verilog/rsh_ctrl.sv
// reference input switching and holdover control for loop 1, with an APB register slave
//
// The APB interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "rsh_map.svh"

module rsh_ctrl #(
	parameter int DIV_W = 14,
	parameter int DAC_W = 10,
	parameter int CNT_W = 16
) (
	input  wire logic              core_clk,
	input  wire logic              reset_n,
	input  wire logic              clkEn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [11:0]       paddr,
	input  wire logic [31:0]       pwdata,
	output var  logic [31:0]       prdata,
	output var  logic              pready,
	output var  logic              pslverr,
	input  wire logic              refInputA,
	input  wire logic              refInputB,
	input  wire logic              feedbackIn,
	input  wire logic              selectPinZero,
	input  wire logic              selectPinOne,
	input  wire logic              loop2LockFlagIn,
	input  wire logic [9:0]        tuneLevel,
	output var  logic              loop1LockFlag,
	output var  logic              loop2LockFlag,
	output var  logic              holdoverStatus,
	output var  logic              chargePumpHiZ,
	output var  logic [9:0]        loop1TuneOut,
	output var  logic              activeInputB,
	output var  logic              lockStatusPin
);
	import rsh_pkg::*;

	initial begin
		if (DIV_W != rsh_pkg::DIV_W || DAC_W != rsh_pkg::DAC_W || CNT_W != rsh_pkg::CNT_W) begin
			$error("rsh_ctrl: widths must match the package widths");
		end
	end

	logic       rstSync1;
	logic       rstSync2;
	rsh_state_t stQ;
	rsh_state_t stD;

	// two-stage release keeps the reset deassertion synchronous
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			rstSync1 <= 1'b0;
			rstSync2 <= 1'b0;
		end else begin
			rstSync1 <= 1'b1;
			rstSync2 <= rstSync1;
		end
	end

	// decoded control fields
	logic [2:0]       selMode;
	logic [1:0]       holdField;
	logic             holdEnabled;
	logic             forceHold;
	logic             lossOff;
	logic             railDetEn;
	logic             trackEn;
	logic             manEn;
	logic [DAC_W-1:0] manValue;
	logic [DAC_W-1:0] lowTrip;
	logic [DAC_W-1:0] highTrip;
	logic [DIV_W-1:0] refDiv;
	logic [DIV_W-1:0] fbDiv;
	logic [CNT_W-1:0] lockWindow;
	logic [CNT_W-1:0] lockTarget;
	logic             autoMode;

	always_comb begin
		selMode     = stQ.ctrl[`RSH_F_MODE_HI:`RSH_F_MODE_LO];
		holdField   = stQ.ctrl[`RSH_F_HOLD_HI:`RSH_F_HOLD_LO];
		holdEnabled = (holdField == `RSH_HOLD_ENABLED);
		forceHold   = stQ.ctrl[`RSH_F_FORCE];
		lossOff     = stQ.ctrl[`RSH_F_LOSS_OFF];
		railDetEn   = stQ.ctrl[`RSH_F_RAIL_EN];
		trackEn     = stQ.ctrl[`RSH_F_TRACK_EN];
		manEn       = stQ.ctrl[`RSH_F_MAN_EN];
		manValue    = stQ.dacMan[DAC_W-1:0];
		lowTrip     = stQ.trip[DAC_W-1:0];
		highTrip    = stQ.trip[DAC_W+15:16];
		refDiv      = stQ.dividers[DIV_W-1:0];
		fbDiv       = stQ.dividers[DIV_W+15:16];
		lockWindow  = stQ.lockCfg[CNT_W-1:0];
		lockTarget  = stQ.lockCfg[CNT_W+15:16];
		autoMode    = (selMode == `RSH_MODE_AUTO) || (selMode == `RSH_MODE_AUTO_PIN);
	end

	// working terms of the next-state process
	logic             selRef;
	logic             refRise;
	logic             fbRise;
	logic             refPulse;
	logic             fbPulse;
	logic             compare;
	logic [CNT_W-1:0] errNow;
	logic             railHit;
	logic             lockFall;
	logic             switchEvt;
	logic             enterHold;
	logic             pinZ;
	logic             pinO;
	logic             holdNext;
	logic             apbAccess;
	logic             apbSetup;
	logic             mapped;
	logic [31:0]      rdValue;

	always_comb begin
		stD       = stQ;
		selRef    = stQ.activeB ? refInputB : refInputA;
		refRise   = selRef & ~stQ.prevRef;
		fbRise    = feedbackIn & ~stQ.prevFb;
		refPulse  = 1'b0;
		fbPulse   = 1'b0;
		compare   = 1'b0;
		errNow    = '0;
		stD.prevRef = selRef;
		stD.prevFb  = feedbackIn;

		if (refRise) begin
			if (stQ.refCnt + 14'h0001 >= refDiv) begin
				stD.refCnt = '0;
				refPulse   = 1'b1;
			end else begin
				stD.refCnt = stQ.refCnt + 14'h0001;
			end
		end
		if (fbRise) begin
			if (stQ.fbCnt + 14'h0001 >= fbDiv) begin
				stD.fbCnt = '0;
				fbPulse   = 1'b1;
			end else begin
				stD.fbCnt = stQ.fbCnt + 14'h0001;
			end
		end

		// phase error measured in core clock cycles between the two divided edges
		if (refPulse && fbPulse) begin
			compare = 1'b1;
			stD.pendRef = 1'b0;
			stD.pendFb  = 1'b0;
		end else if ((refPulse && stQ.pendFb) || (fbPulse && stQ.pendRef)) begin
			compare = 1'b1;
			errNow  = stQ.errCnt;
			stD.pendRef = 1'b0;
			stD.pendFb  = 1'b0;
		end else if (refPulse || fbPulse) begin
			stD.pendRef = refPulse;
			stD.pendFb  = fbPulse;
			stD.errCnt  = '0;
		end else if ((stQ.pendRef || stQ.pendFb) && stQ.errCnt != 16'hFFFF) begin
			stD.errCnt = stQ.errCnt + 16'h0001;
		end

		if (compare) begin
			if (errNow <= lockWindow) begin
				if (stQ.lockCnt + 16'h0001 >= lockTarget) begin
					stD.locked = 1'b1;
				end else begin
					stD.lockCnt = stQ.lockCnt + 16'h0001;
				end
			end else begin
				stD.lockCnt = '0;
				stD.locked  = 1'b0;
			end
		end

		// tracking tick at the divided phase detector rate
		if (trackEn && refPulse) begin
			if (stQ.dacTick + 16'h0001 >= stQ.dacDiv[CNT_W-1:0]) begin
				stD.dacTick = '0;
				// last valid value is frozen while in holdover
				if (stQ.hold == RSH_RUN) begin
					stD.dacCount = tuneLevel;
				end
			end else begin
				stD.dacTick = stQ.dacTick + 16'h0001;
			end
		end

		railHit  = (tuneLevel >= highTrip) || (tuneLevel <= lowTrip);
		stD.lockFlag = stQ.locked && (stQ.hold == RSH_RUN);
		lockFall = stQ.lockFlag && !stD.lockFlag;
		// rearm only after lock flag high
		if (stQ.lockFlag) begin
			stD.armed = 1'b1;
		end
		// lock loss events, not via forced-low flag
		switchEvt = autoMode && stQ.armed && lockFall
			&& (!lossOff || selMode == `RSH_MODE_AUTO_PIN);
		enterHold = forceHold
			|| (holdEnabled && lockFall && !lossOff)
			|| (holdEnabled && autoMode && railDetEn && trackEn && railHit);
		holdNext = (stQ.hold == RSH_HOLD);

		pinZ = selectPinZero ^ stQ.ctrl[`RSH_F_SEL_INV];
		pinO = selectPinOne ^ stQ.ctrl[`RSH_F_SEL_INV];
		if (selMode == `RSH_MODE_MAN_A) begin
			stD.activeB = 1'b0;
		end else if (selMode == `RSH_MODE_MAN_B) begin
			stD.activeB = 1'b1;
		end else if (switchEvt) begin
			stD.armed = 1'b0;
			if (selMode == `RSH_MODE_AUTO_PIN) begin
				if (pinZ) begin
					stD.activeB = 1'b0;
				end else if (pinO) begin
					stD.activeB = 1'b1;
				end
			end else begin
				// next enabled input in priority order
				if (!stQ.activeB && stQ.ctrl[`RSH_F_EN_B]) begin
					stD.activeB = 1'b1;
				end else if (stQ.activeB && stQ.ctrl[`RSH_F_EN_A]) begin
					stD.activeB = 1'b0;
				end
			end
			if (holdEnabled) begin
				holdNext = 1'b1;
			end
		end

		if (enterHold) begin
			holdNext = 1'b1;
		end
		// exit once lock count met on the active input
		if (stQ.hold == RSH_HOLD && stQ.locked && !forceHold && !enterHold && !switchEvt) begin
			holdNext = 1'b0;
		end
		// disable leaves at once, force overrides
		if (!holdEnabled && !forceHold) begin
			holdNext = 1'b0;
		end
		stD.hold = holdNext ? RSH_HOLD : RSH_RUN;
		if (holdNext) begin
			stD.lockFlag = 1'b0;
		end

		// loop-2 lock passes through a flop, untouched by holdover
		stD.loop2Flag = loop2LockFlagIn;
		stD.tuneOut = (manEn || !trackEn) ? manValue : stD.dacCount;

		case (stQ.ctrl[`RSH_F_LDPIN_HI:`RSH_F_LDPIN_LO])
			2'h0: stD.lockPin = stD.lockFlag;
			2'h1: stD.lockPin = loop2LockFlagIn;
			2'h2: stD.lockPin = stD.lockFlag && loop2LockFlagIn;
			default: stD.lockPin = holdNext;
		endcase

		// apb: setup cycle prepares the answer, access edge commits it
		apbSetup  = psel && !penable;
		apbAccess = psel && penable && stQ.pready;
		mapped    = 1'b1;
		rdValue   = 32'h0000_0000;
		case (paddr)
			`RSH_OFF_CTRL:     rdValue = stQ.ctrl;
			`RSH_OFF_DAC_MAN:  rdValue = stQ.dacMan;
			`RSH_OFF_TRIP:     rdValue = stQ.trip;
			`RSH_OFF_DAC_DIV:  rdValue = stQ.dacDiv;
			`RSH_OFF_DIVIDERS: rdValue = stQ.dividers;
			`RSH_OFF_LOCK:     rdValue = stQ.lockCfg;
			`RSH_OFF_STATUS:   rdValue = {6'h00, stQ.dacCount, 11'h000, railHit,
				loop2LockFlagIn, stQ.hold == RSH_HOLD, stQ.lockFlag, stQ.activeB};
			default:           mapped = 1'b0;
		endcase
		stD.pready  = apbSetup;
		stD.pslverr = apbSetup && !mapped;
		stD.prdata  = (apbSetup && !pwrite && mapped) ? rdValue : 32'h0000_0000;
		if (apbAccess && pwrite) begin
			case (paddr)
				`RSH_OFF_CTRL: begin
					stD.ctrl = {17'h00000, pwdata[14:0]};
					// entering mode 6 keeps active input (no manual override)
				end
				`RSH_OFF_DAC_MAN:  stD.dacMan = {22'h000000, pwdata[9:0]};
				`RSH_OFF_TRIP:     stD.trip = {6'h00, pwdata[25:16], 6'h00, pwdata[9:0]};
				`RSH_OFF_DAC_DIV:  stD.dacDiv = {16'h0000, pwdata[15:0]};
				`RSH_OFF_DIVIDERS: stD.dividers = {2'h0, pwdata[29:16], 2'h0, pwdata[13:0]};
				`RSH_OFF_LOCK:     stD.lockCfg = pwdata;
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rstSync2) begin
		if (!rstSync2) begin
			stQ          <= '0;
			stQ.ctrl     <= `RSH_CTRL_RESET;
			stQ.dacMan   <= `RSH_DAC_MAN_RESET;
			stQ.trip     <= `RSH_TRIP_RESET;
			stQ.dacDiv   <= `RSH_DAC_DIV_RESET;
			stQ.dividers <= `RSH_DIVIDERS_RESET;
			stQ.lockCfg  <= `RSH_LOCK_RESET;
			stQ.hold     <= RSH_RUN;
		end else if (clkEn) begin
			stQ <= stD;
		end
	end

	always_comb begin
		prdata         = stQ.prdata;
		pready         = stQ.pready;
		pslverr        = stQ.pslverr;
		loop1LockFlag  = stQ.lockFlag;
		loop2LockFlag  = stQ.loop2Flag;
		holdoverStatus = (stQ.hold == RSH_HOLD);
		chargePumpHiZ  = (stQ.hold == RSH_HOLD);
		loop1TuneOut   = stQ.tuneOut;
		activeInputB   = stQ.activeB;
		lockStatusPin  = stQ.lockPin;
	end
endmodule : rsh_ctrl
`default_nettype wire

// File: tb/rsh_host_model.sv
// host side model: reference clocks, feedback and select pins
`timescale 1ns/10ps
`default_nettype none
module rsh_host_model (
	input  wire logic       core_clk,
	input  wire logic       reset_n,
	input  wire logic       skewFb,
	input  wire logic [1:0] pinReq,
	output var  logic       refInputA,
	output var  logic       refInputB,
	output var  logic       feedbackIn,
	output var  logic       selectPinZero,
	output var  logic       selectPinOne
);
	logic [2:0] phase;
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			phase <= 3'h0;
			selectPinZero <= 1'b0;
			selectPinOne <= 1'b0;
		end else begin
			phase <= phase + 3'h1;
			// pins change only on an edge, so no code is ever half applied
			selectPinZero <= pinReq[0];
			selectPinOne <= pinReq[1];
		end
	end
	assign refInputA = phase[2];
	assign refInputB = phase[2];
	// half a period of skew gives an error count of 3, outside the reset lock window of 2
	assign feedbackIn = skewFb ? ~phase[2] : phase[2];
endmodule : rsh_host_model
`default_nettype wire

// File: tb/rsh_ctrl_asserts.sv
// port level assertions for the reference switch controller
`timescale 1ns/10ps
`default_nettype none
module rsh_ctrl_asserts (
	input wire logic       core_clk,
	input wire logic       reset_n,
	input wire logic       psel,
	input wire logic       pwrite,
	input wire logic       loop2LockFlagIn,
	input wire logic       loop1LockFlag,
	input wire logic       loop2LockFlag,
	input wire logic       holdoverStatus,
	input wire logic       chargePumpHiZ,
	input wire logic [9:0] loop1TuneOut,
	input wire logic       activeInputB
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	logic wr;
	assign wr = psel && pwrite;
	a_hiz_in_hold: assert property (holdoverStatus && $past(holdoverStatus) |-> chargePumpHiZ)
		else $error("charge pump driven in holdover");
	a_hiz_no_run: assert property (!holdoverStatus && !$past(holdoverStatus) |-> !chargePumpHiZ)
		else $error("charge pump off outside holdover");
	a_flag_in_hold: assert property (holdoverStatus && $past(holdoverStatus) |-> !loop1LockFlag)
		else $error("lock flag high in holdover");
	a_loop2_kept: assert property (holdoverStatus && loop2LockFlagIn && $past(loop2LockFlagIn)
		|-> loop2LockFlag)
		else $error("loop 2 lock dropped in holdover");
	a_tune_fixed: assert property (holdoverStatus && $past(holdoverStatus) && !$past(wr)
		&& !$past(wr, 2) |-> $stable(loop1TuneOut))
		else $error("tune value moved in holdover");
	a_input_kept: assert property ($changed(activeInputB)
		|-> !loop1LockFlag || $past(wr) || $past(wr, 2))
		else $error("input changed while locked");
	a_no_second: assert property ($changed(activeInputB) && !$past(wr) && !$past(wr, 2)
		|=> $stable(activeInputB) [*3])
		else $error("second switch without relock");
	a_exit_cause: assert property ($fell(holdoverStatus)
		|-> ($past(wr) || $past(wr, 2)) or ##[0:1] loop1LockFlag)
		else $error("holdover left without lock");
endmodule : rsh_ctrl_asserts
bind rsh_ctrl rsh_ctrl_asserts i_chk (.core_clk(core_clk), .reset_n(reset_n), .psel(psel),
	.pwrite(pwrite), .loop2LockFlagIn(loop2LockFlagIn), .loop1LockFlag(loop1LockFlag),
	.loop2LockFlag(loop2LockFlag), .holdoverStatus(holdoverStatus),
	.chargePumpHiZ(chargePumpHiZ), .loop1TuneOut(loop1TuneOut), .activeInputB(activeInputB));
`default_nettype wire

// File: tb/tb_top.sv
// self-checking bench for the reference switch controller
`timescale 1ns/10ps
`default_nettype none
`include "rsh_map.svh"
module tb_top;
	logic        core_clk = 1'b0;
	logic        reset_n = 1'b0;
	logic        clkEn = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic        loop2LockFlagIn = 1'b0;
	logic [9:0]  tuneLevel = 10'h100;
	logic        skewFb = 1'b0;
	logic [1:0]  pinReq = 2'b01;
	logic [31:0] prdata;
	logic [9:0]  loop1TuneOut;
	logic        pready, pslverr, refInputA, refInputB, feedbackIn, lastErr;
	logic        selectPinZero, selectPinOne, loop1LockFlag, loop2LockFlag;
	logic        holdoverStatus, chargePumpHiZ, activeInputB, lockStatusPin;
	logic [31:0] seed = 32'd52415;
	logic [31:0] rv [6] = '{`RSH_CTRL_RESET, `RSH_DAC_MAN_RESET, `RSH_TRIP_RESET,
		`RSH_DAC_DIV_RESET, `RSH_DIVIDERS_RESET, `RSH_LOCK_RESET};
	int          num_errors = 0;
	int          n_checks = 0;
	always #25 core_clk = ~core_clk;
	rsh_host_model i_host (.core_clk(core_clk), .reset_n(reset_n), .skewFb(skewFb),
		.pinReq(pinReq), .refInputA(refInputA), .refInputB(refInputB),
		.feedbackIn(feedbackIn), .selectPinZero(selectPinZero), .selectPinOne(selectPinOne));
	rsh_ctrl i_dut (.core_clk(core_clk), .reset_n(reset_n), .clkEn(clkEn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .refInputA(refInputA),
		.refInputB(refInputB), .feedbackIn(feedbackIn), .selectPinZero(selectPinZero),
		.selectPinOne(selectPinOne), .loop2LockFlagIn(loop2LockFlagIn),
		.tuneLevel(tuneLevel), .loop1LockFlag(loop1LockFlag), .loop2LockFlag(loop2LockFlag),
		.holdoverStatus(holdoverStatus), .chargePumpHiZ(chargePumpHiZ),
		.loop1TuneOut(loop1TuneOut), .activeInputB(activeInputB),
		.lockStatusPin(lockStatusPin));
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	// input picked at a pin switch event: 1 means B, reserved code keeps prev
	function automatic int expSel(input int pins, input int inv, input int prev);
		int p;
		p = pins ^ (inv * 3);
		if ((p & 1) != 0) return 0;
		if ((p & 2) != 0) return 1;
		return prev;
	endfunction : expSel
	task automatic wrap_up();
		if (num_errors == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : wrap_up
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic waitv(ref logic s, input logic v);
		int n;
		n = 0;
		while (s !== v && n < 3000) begin
			@(posedge core_clk);
			n++;
		end
		if (n >= 3000) begin
			num_errors++;
			wrap_up();
		end
	endtask : waitv
	// idle edge after each transfer keeps the strobes from being set twice in one step
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r);
		int n;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		r = prdata;
		lastErr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50) begin
			num_errors++;
			wrap_up();
		end
		@(posedge core_clk);
	endtask : apb
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		apb(1'b1, a, d, r);
	endtask : wr
	initial begin
		logic [31:0] r, dv;
		int prev, e;
		int cases [5][2] = '{'{2, 0}, '{1, 0}, '{0, 0}, '{1, 1}, '{3, 0}};
		repeat (20) @(posedge core_clk);
		reset_n <= 1'b1;
		tuneLevel <= 10'h020 + 10'(rnd() & 32'hFF);
		repeat (3) @(posedge core_clk);
		for (int i = 0; i < 6; i++) begin
			apb(1'b0, 12'(i * 4), 32'h0, r);
			chk(r, rv[i]);
		end
		apb(1'b0, 12'h01C, 32'h0, r);
		chk(r, 32'h0);
		chk(32'(lastErr), 32'h1);
		loop2LockFlagIn <= 1'b1;
		wr(`RSH_OFF_DAC_DIV, 32'd32);
		wr(`RSH_OFF_CTRL, 32'h1820);
		waitv(loop1LockFlag, 1'b1);
		wr(`RSH_OFF_CTRL, 32'h1826);
		chk(32'(activeInputB), 32'h0);
		prev = 0;
		for (int k = 0; k < 5; k++) begin
			pinReq <= 2'(cases[k][0]);
			wr(`RSH_OFF_CTRL, 32'h1826 | 32'(cases[k][1] << 3));
			chk(32'(activeInputB), 32'(prev));
			skewFb <= 1'b1;
			waitv(holdoverStatus, 1'b1);
			skewFb <= 1'b0;
			waitv(loop1LockFlag, 1'b1);
			e = expSel(cases[k][0], cases[k][1], prev);
			chk(32'(activeInputB), 32'(e));
			chk(32'(holdoverStatus), 32'h0);
			prev = e;
		end
		dv = rnd() & 32'h3FF;
		wr(`RSH_OFF_DAC_MAN, dv);
		wr(`RSH_OFF_CTRL, 32'h7C66);
		waitv(holdoverStatus, 1'b1);
		chk(32'(chargePumpHiZ), 32'h1);
		chk(32'(loop1TuneOut), dv);
		chk(32'(loop1LockFlag), 32'h0);
		chk(32'(loop2LockFlag), 32'h1);
		chk(32'(lockStatusPin), 32'h1);
		wr(`RSH_OFF_CTRL, 32'h1806);
		waitv(holdoverStatus, 1'b0);
		wr(`RSH_OFF_CTRL, 32'h1F26);
		tuneLevel <= 10'h3FF;
		waitv(holdoverStatus, 1'b1);
		chk(32'(loop1TuneOut), dv);
		wrap_up();
	end
endmodule : tb_top
`default_nettype wire
